/* File: core/ptc_capture_config.sv */
// Timestamp capture configuration and capture control for ports 2 and 1.
// Assumes frame events arrive as one-cycle valid pulses, synchronous to clk,
// and the free-running PTP clock value is supplied from outside.
//
// Contract
// [RULE_01] Port 2 master: capture Sync tx, Delay_Req rx
// [RULE_02] Port 2 slave: capture Delay_Req tx, Sync rx
// [RULE_03] Port 1 role bit selects same behaviour
// [RULE_04] Port 2 primary address enable, resets set
// [RULE_05] Port 2 alternate one enable, resets clear
// [RULE_06] Port 2 alternate two enable, resets clear
// [RULE_07] Port 2 alternate three enable, resets clear
// [RULE_08] Port 2 custom address enable, resets clear
// [RULE_09] Port 2 rx lock keeps pending capture
// [RULE_10] Port 2 tx lock keeps pending capture
// [RULE_11] Rx lock off: new capture overwrites
// [RULE_12] Config register at 194h, fully read/write
// [RULE_13] Auxiliary address is upper16 plus lower32
// [RULE_14] Only enabled destination addresses trigger capture
//
// Decided for this implementation: strobed register access.
`default_nettype none

module ptc_capture_config
    import ptc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [PTC_ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    // Time base
    input wire logic [63:0] ptpClock,
    // Frame events, indexed by capture unit
    input wire ptc_frame_s [PTC_NUM_UNITS-1:0] frameIn,
    // Capture results
    output ptc_capture_s [PTC_NUM_UNITS-1:0] capture,
    output logic [PTC_NUM_UNITS-1:0] captureEvent,
    // Interrupt
    output logic irq
);

    // ****************************************************************
    // Register state
    // ****************************************************************
    logic [31:0] config_r;
    logic [31:0] config_nxt;
    logic [15:0] auxUpper_r;
    logic [15:0] auxUpper_nxt;
    logic [31:0] auxLower_r;
    logic [31:0] auxLower_nxt;
    logic [PTC_NUM_UNITS-1:0] intStatus_r;
    logic [PTC_NUM_UNITS-1:0] intStatus_nxt;
    logic [PTC_NUM_UNITS-1:0] intEnable_r;
    logic [PTC_NUM_UNITS-1:0] intEnable_nxt;
    logic [31:0] rdData_r;
    logic [31:0] rdData_nxt;
    logic [PTC_NUM_UNITS-1:0] event_r;
    logic [PTC_NUM_UNITS-1:0] event_nxt;

    // ****************************************************************
    // Decoded configuration
    // ****************************************************************
    logic [47:0] auxAddr;
    logic port2MasterSelect;
    logic port1MasterSelect;
    logic port2PrimaryAddrEnable;
    logic port2AlternateOneEnable;
    logic port2AlternateTwoEnable;
    logic port2AlternateThreeEnable;
    logic port2CustomAddrEnable;
    logic [4:0] port2AddrEnables;
    logic [4:0] port1AddrEnables;
    logic [PTC_NUM_UNITS-1:0] unitMaster;
    logic [PTC_NUM_UNITS-1:0] unitIsTx;
    logic [PTC_NUM_UNITS-1:0] unitLock;
    logic [PTC_NUM_UNITS-1:0] hit;
    logic [PTC_NUM_UNITS-1:0] store;
    logic [PTC_NUM_UNITS-1:0] clearMask;
    ptc_capture_s [PTC_NUM_UNITS-1:0] captureIn;

    assign auxAddr = {auxUpper_r, auxLower_r}; // RULE_13

    assign port2MasterSelect = config_r[PTC_BIT_P2_MASTER];
    assign port1MasterSelect = config_r[PTC_BIT_P1_MASTER];
    assign port2PrimaryAddrEnable = config_r[PTC_BIT_P2_ADDR_EN_HI];
    assign port2AlternateOneEnable = config_r[PTC_BIT_P2_ADDR_EN_HI - 1];
    assign port2AlternateTwoEnable = config_r[PTC_BIT_P2_ADDR_EN_HI - 2];
    assign port2AlternateThreeEnable = config_r[PTC_BIT_P2_ADDR_EN_HI - 3];
    assign port2CustomAddrEnable = config_r[PTC_BIT_P2_ADDR_EN_LO];

    assign port2AddrEnables = {
        port2PrimaryAddrEnable,    // RULE_04
        port2AlternateOneEnable,   // RULE_05
        port2AlternateTwoEnable,   // RULE_06
        port2AlternateThreeEnable, // RULE_07
        port2CustomAddrEnable      // RULE_08
    };
    assign port1AddrEnables = config_r[PTC_BIT_P1_ADDR_EN_HI:PTC_BIT_P1_ADDR_EN_LO];

    // ****************************************************************
    // Per-unit role, direction and lock
    // ****************************************************************
    always_comb begin
        unitMaster = '0;
        unitIsTx = '0;
        unitLock = '0;
        unitMaster[PTC_UNIT_P2_RX] = port2MasterSelect; // RULE_01
        unitMaster[PTC_UNIT_P2_TX] = port2MasterSelect; // RULE_02
        unitMaster[PTC_UNIT_P1_RX] = port1MasterSelect; // RULE_03
        unitMaster[PTC_UNIT_P1_TX] = port1MasterSelect; // RULE_03
        unitIsTx[PTC_UNIT_P2_TX] = 1'b1;
        unitIsTx[PTC_UNIT_P1_TX] = 1'b1;
        unitLock[PTC_UNIT_P2_RX] = config_r[PTC_BIT_P2_LOCK_RX];
        unitLock[PTC_UNIT_P2_TX] = config_r[PTC_BIT_P2_LOCK_TX];
        unitLock[PTC_UNIT_P1_RX] = config_r[PTC_BIT_P1_LOCK_RX];
        unitLock[PTC_UNIT_P1_TX] = config_r[PTC_BIT_P1_LOCK_TX];
    end

    // ****************************************************************
    // Capture decision
    // ****************************************************************
    // The lock only blocks overwriting; the event still reports, so
    // software sees that a later message was missed while it was busy.
    always_comb begin
        hit = '0;
        store = '0;
        for (int u = 0; u < PTC_NUM_UNITS; u++) begin
            hit[u] = frameIn[u].valid
                && ptc_addr_hit(frameIn[u].destAddr,
                    (u < PTC_UNIT_P1_RX) ? port2AddrEnables : port1AddrEnables,
                    auxAddr) // RULE_14
                && ptc_type_hit(unitMaster[u], unitIsTx[u], frameIn[u].msgType); // RULE_01
            store[u] = hit[u] && !(unitLock[u] && intStatus_r[u]); // RULE_09 RULE_10 RULE_11
        end
    end

    always_comb begin
        for (int u = 0; u < PTC_NUM_UNITS; u++) begin
            captureIn[u].clockValue = ptpClock;
            captureIn[u].sourceUniqueIdentifier = frameIn[u].sourceUniqueIdentifier;
            captureIn[u].seqId = frameIn[u].seqId;
        end
    end

    for (genvar g = 0; g < PTC_NUM_UNITS; g++) begin : gen_unit
        ptc_capture_unit u_store (
            .clk(clk),
            .rst_n(rst_n),
            .store(store[g]),
            .dataIn(captureIn[g]),
            .capture(capture[g])
        );
    end

    // ****************************************************************
    // Configuration register
    // ****************************************************************
    always_comb begin
        config_nxt = config_r;
        if (regWr && regAddr == PTC_OFS_CONFIG) begin
            config_nxt = regWrData; // RULE_12
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            config_r <= PTC_CONFIG_RESET; // RULE_04 RULE_05 RULE_09 RULE_10
        end else begin
            config_r <= config_nxt;
        end
    end

    // ****************************************************************
    // Auxiliary address
    // ****************************************************************
    always_comb begin
        auxUpper_nxt = auxUpper_r;
        auxLower_nxt = auxLower_r;
        if (regWr && regAddr == PTC_OFS_AUX_UPPER) begin
            auxUpper_nxt = regWrData[15:0]; // RULE_13
        end
        if (regWr && regAddr == PTC_OFS_AUX_LOWER) begin
            auxLower_nxt = regWrData; // RULE_13
        end
    end

    // Halves are written apart, so a half-updated address can match briefly
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            auxUpper_r <= PTC_AUX_UPPER_RESET;
            auxLower_r <= PTC_AUX_LOWER_RESET;
        end else begin
            auxUpper_r <= auxUpper_nxt;
            auxLower_r <= auxLower_nxt;
        end
    end

    // ****************************************************************
    // Interrupt status, enable and clear
    // ****************************************************************
    always_comb begin
        intEnable_nxt = intEnable_r;
        clearMask = '0;
        if (regWr && regAddr == PTC_OFS_INT_ENABLE) begin
            intEnable_nxt = regWrData[PTC_NUM_UNITS-1:0];
        end
        if (regWr && regAddr == PTC_OFS_INT_CLEAR) begin
            clearMask = regWrData[PTC_NUM_UNITS-1:0];
        end
        // A capture in the clearing cycle keeps its bit set
        intStatus_nxt = (intStatus_r & ~clearMask) | hit;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            intStatus_r <= '0;
            intEnable_r <= '0;
        end else begin
            intStatus_r <= intStatus_nxt;
            intEnable_r <= intEnable_nxt;
        end
    end

    // ****************************************************************
    // Capture event pulse
    // ****************************************************************
    always_comb begin
        event_nxt = hit;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            event_r <= '0;
        end else begin
            event_r <= event_nxt;
        end
    end

    // ****************************************************************
    // Register reads, data one cycle after the strobe
    // ****************************************************************
    always_comb begin
        rdData_nxt = '0;
        if (regRd) begin
            unique case (regAddr)
                PTC_OFS_CONFIG: rdData_nxt = config_r; // RULE_12
                PTC_OFS_AUX_UPPER: rdData_nxt = {16'h0000, auxUpper_r};
                PTC_OFS_AUX_LOWER: rdData_nxt = auxLower_r;
                PTC_OFS_INT_STATUS: rdData_nxt[PTC_NUM_UNITS-1:0] = intStatus_r;
                PTC_OFS_INT_ENABLE: rdData_nxt[PTC_NUM_UNITS-1:0] = intEnable_r;
                default: rdData_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdData_r <= '0;
        end else begin
            rdData_r <= rdData_nxt;
        end
    end

    assign regRdData = rdData_r;
    assign captureEvent = event_r;
    assign irq = |(intStatus_r & intEnable_r);

endmodule

`default_nettype wire

/* File: core/ptc_pkg.sv */
// Package for the timestamp capture configuration block: register map,
// field positions, reset values, PTP addresses and shared decode functions.
// Assumes a 32-bit word register port and synchronous frame event inputs.
`default_nettype none

package ptc_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam int PTC_ADDR_W = 12;
    localparam logic [11:0] PTC_OFS_AUX_UPPER = 12'h18C;
    localparam logic [11:0] PTC_OFS_AUX_LOWER = 12'h190;
    localparam logic [11:0] PTC_OFS_CONFIG = 12'h194;
    localparam logic [11:0] PTC_OFS_INT_STATUS = 12'h1A0;
    localparam logic [11:0] PTC_OFS_INT_ENABLE = 12'h1A4;
    localparam logic [11:0] PTC_OFS_INT_CLEAR = 12'h1A8;

    // ****************************************************************
    // Configuration register fields and reset values
    // ****************************************************************
    localparam int PTC_BIT_P2_MASTER = 31;
    localparam int PTC_BIT_P2_ADDR_EN_HI = 30;
    localparam int PTC_BIT_P2_ADDR_EN_LO = 26;
    localparam int PTC_BIT_P2_LOCK_RX = 25;
    localparam int PTC_BIT_P2_LOCK_TX = 24;
    localparam int PTC_BIT_P1_MASTER = 23;
    localparam int PTC_BIT_P1_ADDR_EN_HI = 22;
    localparam int PTC_BIT_P1_ADDR_EN_LO = 18;
    localparam int PTC_BIT_P1_LOCK_RX = 17;
    localparam int PTC_BIT_P1_LOCK_TX = 16;
    localparam logic [31:0] PTC_CONFIG_RESET = 32'h4343_4000;
    localparam logic [15:0] PTC_AUX_UPPER_RESET = 16'h0000;
    localparam logic [31:0] PTC_AUX_LOWER_RESET = 32'h0000_0000;

    // Address enable vector: [4] primary, [3:1] alternates one..three, [0] custom
    localparam int PTC_EN_PRIMARY = 4;
    localparam int PTC_EN_ALT_ONE = 3;
    localparam int PTC_EN_ALT_TWO = 2;
    localparam int PTC_EN_ALT_THREE = 1;
    localparam int PTC_EN_CUSTOM = 0;

    localparam logic [47:0] PTC_MAC_PRIMARY = 48'h0100_5E00_0181;
    localparam logic [47:0] PTC_MAC_ALT_ONE = 48'h0100_5E00_0182;
    localparam logic [47:0] PTC_MAC_ALT_TWO = 48'h0100_5E00_0183;
    localparam logic [47:0] PTC_MAC_ALT_THREE = 48'h0100_5E00_0184;

    // PTP message type codes
    localparam logic [3:0] PTC_MSG_SYNC = 4'h0;
    localparam logic [3:0] PTC_MSG_DELAY_REQ = 4'h1;

    // ****************************************************************
    // Capture units: index also is the interrupt status bit
    // ****************************************************************
    localparam int PTC_NUM_UNITS = 4;
    localparam int PTC_UNIT_P2_RX = 0;
    localparam int PTC_UNIT_P2_TX = 1;
    localparam int PTC_UNIT_P1_RX = 2;
    localparam int PTC_UNIT_P1_TX = 3;

    typedef struct packed {
        logic valid;
        logic [47:0] destAddr;
        logic [3:0] msgType;
        logic [47:0] sourceUniqueIdentifier;
        logic [15:0] seqId;
    } ptc_frame_s;

    typedef struct packed {
        logic [63:0] clockValue;
        logic [47:0] sourceUniqueIdentifier;
        logic [15:0] seqId;
    } ptc_capture_s;

    localparam ptc_capture_s PTC_CAPTURE_RESET = '0;

    // ****************************************************************
    // Shared decode functions
    // ****************************************************************
    function automatic logic ptc_addr_hit(input logic [47:0] dest, input logic [4:0] en,
                                          input logic [47:0] aux);
        ptc_addr_hit = (en[PTC_EN_PRIMARY] && dest == PTC_MAC_PRIMARY)
                     || (en[PTC_EN_ALT_ONE] && dest == PTC_MAC_ALT_ONE)
                     || (en[PTC_EN_ALT_TWO] && dest == PTC_MAC_ALT_TWO)
                     || (en[PTC_EN_ALT_THREE] && dest == PTC_MAC_ALT_THREE)
                     || (en[PTC_EN_CUSTOM] && dest == aux);
    endfunction

    // Master captures Sync out and Delay_Req in; slave the reverse
    function automatic logic ptc_type_hit(input logic master, input logic isTx,
                                          input logic [3:0] msgType);
        logic [3:0] want;
        want = (master == isTx) ? PTC_MSG_SYNC : PTC_MSG_DELAY_REQ;
        ptc_type_hit = (msgType == want);
    endfunction

endpackage

`default_nettype wire

/* File: core/ptc_capture_unit.sv */
// One capture store: holds clock, source identifier and sequence id.
// Assumes the caller has already applied address, role and lock decisions.
`default_nettype none

module ptc_capture_unit
    import ptc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Capture request
    input wire logic store,
    input wire ptc_capture_s dataIn,
    // Stored values
    output ptc_capture_s capture
);

    ptc_capture_s capture_r;
    ptc_capture_s capture_nxt;

    always_comb begin
        capture_nxt = capture_r;
        if (store) begin
            capture_nxt = dataIn;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            capture_r <= PTC_CAPTURE_RESET;
        end else begin
            capture_r <= capture_nxt;
        end
    end

    assign capture = capture_r;

endmodule

`default_nettype wire

/* File: tb/ptc_capture_config_props.sv */
// Checker for the capture configuration block: read timing, role, address and lock.
// Sees only the top module's ports; software state is shadowed from register writes.
`default_nettype none

module ptc_capture_config_props
    import ptc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [PTC_ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [31:0] regRdData,
    // Capture side
    input wire logic [63:0] ptpClock,
    input wire ptc_frame_s [PTC_NUM_UNITS-1:0] frameIn,
    input wire ptc_capture_s [PTC_NUM_UNITS-1:0] capture,
    input wire logic [PTC_NUM_UNITS-1:0] captureEvent,
    input wire logic irq
);
    // ****************************************************************
    // Shadow state
    // ****************************************************************
    logic [31:0] cfg_r;
    logic [47:0] aux_r;
    logic [3:0] stat_r;
    logic hit;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r <= PTC_CONFIG_RESET;
            aux_r <= '0;
            stat_r <= '0;
        end else begin
            cfg_r <= (regWr && regAddr == PTC_OFS_CONFIG) ? regWrData : cfg_r;
            aux_r[47:32] <= (regWr && regAddr == PTC_OFS_AUX_UPPER) ? regWrData[15:0]
                            : aux_r[47:32];
            aux_r[31:0] <= (regWr && regAddr == PTC_OFS_AUX_LOWER) ? regWrData : aux_r[31:0];
            // Status minus the capture reported now: status is this or captureEvent
            stat_r <= (stat_r | captureEvent)
                      & ~((regWr && regAddr == PTC_OFS_INT_CLEAR) ? regWrData[3:0] : 4'h0);
        end
    end

    always_comb begin
        hit = (cfg_r[30] && frameIn[1].destAddr == PTC_MAC_PRIMARY)
            || (cfg_r[29] && frameIn[1].destAddr == PTC_MAC_ALT_ONE)
            || (cfg_r[28] && frameIn[1].destAddr == PTC_MAC_ALT_TWO)
            || (cfg_r[27] && frameIn[1].destAddr == PTC_MAC_ALT_THREE)
            || (cfg_r[26] && frameIn[1].destAddr == aux_r);
    end

    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence cfgRead;
        regRd && regAddr == PTC_OFS_CONFIG;
    endsequence

    // A capture taken while its lock is on and its status still pending
    sequence lockedCapture(u, b);
        captureEvent[u] && $past(cfg_r[b] && (stat_r[u] || captureEvent[u]));
    endsequence

    rd_idle_a: assert property (!$past(regRd) |-> regRdData == 32'h0)
        else $error("read data not zero outside read cycle");
    rd_cfg_a: assert property (cfgRead |=> regRdData == $past(cfg_r))
        else $error("configuration read back wrong");
    tx2_role_a: assert property (captureEvent[1] |->
        $past(frameIn[1].msgType == (cfg_r[31] ? PTC_MSG_SYNC : PTC_MSG_DELAY_REQ)))
        else $error("port 2 transmit captured wrong message type");
    rx2_role_a: assert property (captureEvent[0] |->
        $past(frameIn[0].msgType == (cfg_r[31] ? PTC_MSG_DELAY_REQ : PTC_MSG_SYNC)))
        else $error("port 2 receive captured wrong message type");
    p1_role_a: assert property (captureEvent[3] |->
        $past(frameIn[3].msgType == (cfg_r[23] ? PTC_MSG_SYNC : PTC_MSG_DELAY_REQ)))
        else $error("port 1 transmit captured wrong message type");
    addr_hit_a: assert property (captureEvent[1] |-> $past(hit))
        else $error("capture on a disabled address");
    rx_lock_a: assert property (lockedCapture(0, 25) |-> $stable(capture[0]))
        else $error("receive lock overwritten");
    tx_lock_a: assert property (lockedCapture(1, 24) |-> $stable(capture[1]))
        else $error("transmit lock overwritten");

    for (genvar u = 0; u < PTC_NUM_UNITS; u++) begin : g_unit
        evt_cause_a: assert property (captureEvent[u] |-> $past(frameIn[u].valid))
            else $error("capture event without a frame");
        store_value_a: assert property ($changed(capture[u]) |->
            captureEvent[u] && capture[u].clockValue == $past(ptpClock))
            else $error("capture changed without a qualifying frame");
    end
endmodule

bind ptc_capture_config ptc_capture_config_props i_ptc_capture_config_props (
    .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .ptpClock(ptpClock), .frameIn(frameIn),
    .capture(capture), .captureEvent(captureEvent), .irq(irq)
);

`default_nettype wire

/* File: tb/ptc_link_partner.sv */
// Link partner model: presents frames to the capture units as one-cycle pulses.
// Assumes the bench calls send; frames are spaced by at least one idle cycle.
`default_nettype none

module ptc_link_partner
    import ptc_pkg::*;
(
    // Clock
    input wire logic clk,
    // Frames toward the capture units
    output ptc_frame_s [PTC_NUM_UNITS-1:0] frameOut
);
    initial frameOut = '0;

    // Fields invert once valid drops, so stale data is never mistaken for held data
    task automatic send(input int u, input logic [47:0] dest, input logic [3:0] kind,
                        input logic [15:0] seq);
        @(posedge clk);
        frameOut[u] <= {1'b1, dest, kind, {seq, seq, seq}, seq};
        @(posedge clk);
        frameOut[u] <= {1'b0, ~dest, ~kind, ~{seq, seq, seq}, ~seq};
    endtask
endmodule

`default_nettype wire

/* File: tb/ptc_capture_config_bench.sv */
// Self-checking bench for the capture configuration block: registers, role,
// address enables, locks and interrupt. One 100 MHz clock, no other sources.
`default_nettype none

module ptc_capture_config_bench
    import ptc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [PTC_ADDR_W-1:0] regAddr = '0;
    logic [31:0] regWrData = '0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [31:0] regRdData;
    logic [63:0] ptpClock = '0;
    ptc_frame_s [PTC_NUM_UNITS-1:0] frameIn;
    ptc_capture_s [PTC_NUM_UNITS-1:0] capture;
    logic [PTC_NUM_UNITS-1:0] captureEvent;
    logic irq;
    int numErrors = 0;
    int nChecks = 0;
    logic [47:0] macs [5] = '{PTC_MAC_PRIMARY, PTC_MAC_ALT_ONE, PTC_MAC_ALT_TWO,
                              PTC_MAC_ALT_THREE, 48'h1234_5678_9ABC};

    ptc_capture_config i_ptc_capture_config (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .ptpClock(ptpClock), .frameIn(frameIn), .capture(capture),
        .captureEvent(captureEvent), .irq(irq));
    ptc_link_partner i_ptc_link_partner (.clk(clk), .frameOut(frameIn));

    initial begin
        forever #5 clk = ~clk;
    end

    // The time base doubles as the hang limit
    always @(posedge clk) begin
        ptpClock <= ptpClock + 64'h1;
        if (ptpClock == 64'h1388) begin
            numErrors++;
            tally_and_finish();
        end
    end

    // ****************************************************************
    // Access tasks
    // ****************************************************************
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        nChecks++;
        if (seen !== exp) begin
            numErrors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("Checks %0d, errors %0d", nChecks, numErrors);
        if (numErrors == 0 && nChecks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        chk(64'(regRdData), 64'(exp));
    endtask

    // Sends one frame; e says a capture event is due, keep says stored values must hold
    task automatic fr(input int u, input logic [47:0] d, input logic [3:0] k,
                      input logic [15:0] s, input logic e, input logic keep);
        ptc_capture_s old;
        old = capture[u];
        i_ptc_link_partner.send(u, d, k, s);
        #1;
        chk(64'(captureEvent[u]), 64'(e));
        if (e && !keep) begin
            chk({capture[u].seqId, capture[u].sourceUniqueIdentifier}, {s, s, s, s});
            chk(capture[u].clockValue, ptpClock - 64'h1);
        end else begin
            chk({capture[u].seqId, capture[u].sourceUniqueIdentifier},
                {old.seqId, old.sourceUniqueIdentifier});
            chk(capture[u].clockValue, old.clockValue);
        end
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        logic [3:0] kd;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd(PTC_OFS_CONFIG, PTC_CONFIG_RESET);
        rd(PTC_OFS_AUX_UPPER, 32'h0);
        wr(12'h1FC, 32'hFFFF_FFFF);
        rd(12'h1FC, 32'h0);
        wr(PTC_OFS_INT_STATUS, 32'hF);
        rd(PTC_OFS_INT_STATUS, 32'h0);
        wr(PTC_OFS_CONFIG, 32'hFFFF_FFFF);
        rd(PTC_OFS_CONFIG, 32'hFFFF_FFFF);
        wr(PTC_OFS_CONFIG, 32'h0);
        rd(PTC_OFS_CONFIG, 32'h0);
        // Locks off and status never cleared, so every capture overwrites
        for (int m = 0; m < 2; m++) begin
            wr(PTC_OFS_CONFIG, 32'h4040_0000 | (m != 0 ? 32'h8080_0000 : 32'h0));
            for (int u = 0; u < PTC_NUM_UNITS; u++) begin
                for (int k = 0; k < 2; k++) begin
                    fr(u, PTC_MAC_PRIMARY, 4'(k), 16'(u * 2 + k + m * 8),
                       (k == 0) == (m == u % 2), 1'b0);
                end
            end
        end
        wr(PTC_OFS_AUX_UPPER, 32'h0000_1234);
        wr(PTC_OFS_AUX_LOWER, 32'h5678_9ABC);
        rd(PTC_OFS_AUX_LOWER, 32'h5678_9ABC);
        for (int i = 0; i < 5; i++) begin
            wr(PTC_OFS_CONFIG, 32'h8080_0000 | (32'h4040_0000 >> i));
            for (int j = 0; j < 5; j++) begin
                fr(1, macs[j], PTC_MSG_SYNC, 16'(i * 5 + j + 32), i == j,
                   1'b0);
                fr(3, macs[j], PTC_MSG_SYNC, 16'(i * 5 + j + 64), i == j, 1'b0);
            end
        end
        // Port 1 locks follow the port 2 pattern
        for (int u = 0; u < PTC_NUM_UNITS; u++) begin
            kd = (u % 2 != 0) ? PTC_MSG_SYNC : PTC_MSG_DELAY_REQ;
            wr(PTC_OFS_CONFIG, 32'hC3C3_0000);
            wr(PTC_OFS_INT_CLEAR, 32'hF);
            wr(PTC_OFS_INT_ENABLE, 32'h1 << u);
            chk(64'(irq), 64'h0);
            fr(u, PTC_MAC_PRIMARY, kd, 16'h00A0, 1'b1, 1'b0);
            chk(64'(irq), 64'h1);
            fr(u, PTC_MAC_PRIMARY, kd, 16'h00B0, 1'b1, 1'b1);
            rd(PTC_OFS_INT_STATUS, 32'h1 << u);
            wr(PTC_OFS_INT_ENABLE, 32'h0);
            chk(64'(irq), 64'h0);
            wr(PTC_OFS_INT_ENABLE, 32'h1 << u);
            chk(64'(irq), 64'h1);
            wr(PTC_OFS_INT_CLEAR, 32'h1 << u);
            chk(64'(irq), 64'h0);
            fr(u, PTC_MAC_PRIMARY, kd, 16'h00C0, 1'b1, 1'b0);
        end
        tally_and_finish();
    end
endmodule

`default_nettype wire
